// ===== design/cpu_core_register_file.sv
module cpu_core_register_file (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [31:0] busRdata,
  input wire regfile_pkg::dp_req_t dpReq,
  input wire regfile_pkg::alu_flags_t aluFlags,
  output logic [31:0] dpRdData,
  output regfile_pkg::cpu_view_t view
);

  // ==========================================================
  // Operand read; banked registers always come from the bank the flag selects
  function automatic logic [31:0] readSel(
    input regfile_pkg::regfile_state_t s,
    input logic [4:0] sel
  );
    logic b;
    logic [31:0] r;
    b = s.flags[regfile_pkg::FLAG_B];
    r = 32'h0;
    case (sel)
      regfile_pkg::SEL_DATA0: r = {16'h0, s.bank[b].data[0]};
      regfile_pkg::SEL_DATA1: r = {16'h0, s.bank[b].data[1]};
      regfile_pkg::SEL_DATA2: r = {16'h0, s.bank[b].data[2]};
      regfile_pkg::SEL_DATA3: r = {16'h0, s.bank[b].data[3]};
      regfile_pkg::SEL_ADDR_FIRST: r = {16'h0, s.bank[b].addr[0]};
      regfile_pkg::SEL_ADDR_SECOND: r = {16'h0, s.bank[b].addr[1]};
      regfile_pkg::SEL_FRAME_BASE: r = {16'h0, s.bank[b].frameBase};
      regfile_pkg::SEL_VTB: r = {12'h0, s.vtb};
      regfile_pkg::SEL_PC: r = {12'h0, s.pc};
      regfile_pkg::SEL_USP: r = {16'h0, s.user_stack_ptr};
      regfile_pkg::SEL_ISP: r = {16'h0, s.interrupt_stack_ptr};
      regfile_pkg::SEL_STATIC_BASE: r = {16'h0, s.sb};
      regfile_pkg::SEL_FLAGS: r = {21'h0, s.flags};
      regfile_pkg::SEL_DATA_PAIR_LOW: r = {s.bank[b].data[2], s.bank[b].data[0]};
      regfile_pkg::SEL_DATA_PAIR_HIGH: r = {s.bank[b].data[3], s.bank[b].data[1]};
      regfile_pkg::SEL_ADDR_PAIR: r = {s.bank[b].addr[1], s.bank[b].addr[0]};
      regfile_pkg::SEL_D0_UPPER: r = {24'h0, s.bank[b].data[0][15:8]};
      regfile_pkg::SEL_D0_LOWER: r = {24'h0, s.bank[b].data[0][7:0]};
      regfile_pkg::SEL_D1_UPPER: r = {24'h0, s.bank[b].data[1][15:8]};
      regfile_pkg::SEL_D1_LOWER: r = {24'h0, s.bank[b].data[1][7:0]};
      regfile_pkg::SEL_ACTIVE_SP: r = {16'h0, s.flags[regfile_pkg::FLAG_U] ? s.interrupt_stack_ptr : s.user_stack_ptr};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Register write; banked registers go to the selected copy only
  function automatic regfile_pkg::regfile_state_t writeSel(
    input regfile_pkg::regfile_state_t s,
    input logic [4:0] sel,
    input logic [31:0] d
  );
    regfile_pkg::regfile_state_t n;
    logic b;
    n = s;
    b = s.flags[regfile_pkg::FLAG_B];
    case (sel)
      regfile_pkg::SEL_DATA0: n.bank[b].data[0] = d[15:0];
      regfile_pkg::SEL_DATA1: n.bank[b].data[1] = d[15:0];
      regfile_pkg::SEL_DATA2: n.bank[b].data[2] = d[15:0];
      regfile_pkg::SEL_DATA3: n.bank[b].data[3] = d[15:0];
      regfile_pkg::SEL_ADDR_FIRST: n.bank[b].addr[0] = d[15:0];
      regfile_pkg::SEL_ADDR_SECOND: n.bank[b].addr[1] = d[15:0];
      regfile_pkg::SEL_FRAME_BASE: n.bank[b].frameBase = d[15:0];
      regfile_pkg::SEL_VTB: n.vtb = d[19:0];
      regfile_pkg::SEL_PC: n.pc = d[19:0];
      regfile_pkg::SEL_USP: n.user_stack_ptr = d[15:0];
      regfile_pkg::SEL_ISP: n.interrupt_stack_ptr = d[15:0];
      regfile_pkg::SEL_STATIC_BASE: n.sb = d[15:0];
      regfile_pkg::SEL_FLAGS: n.flags = d[10:0];
      regfile_pkg::SEL_DATA_PAIR_LOW: begin
        n.bank[b].data[0] = d[15:0];
        n.bank[b].data[2] = d[31:16];
      end
      regfile_pkg::SEL_DATA_PAIR_HIGH: begin
        n.bank[b].data[1] = d[15:0];
        n.bank[b].data[3] = d[31:16];
      end
      regfile_pkg::SEL_ADDR_PAIR: begin
        n.bank[b].addr[0] = d[15:0];
        n.bank[b].addr[1] = d[31:16];
      end
      regfile_pkg::SEL_D0_UPPER: n.bank[b].data[0][15:8] = d[7:0];
      regfile_pkg::SEL_D0_LOWER: n.bank[b].data[0][7:0] = d[7:0];
      regfile_pkg::SEL_D1_UPPER: n.bank[b].data[1][15:8] = d[7:0];
      regfile_pkg::SEL_D1_LOWER: n.bank[b].data[1][7:0] = d[7:0];
      regfile_pkg::SEL_ACTIVE_SP: begin
        if (s.flags[regfile_pkg::FLAG_U]) begin
          n.interrupt_stack_ptr = d[15:0];
        end else begin
          n.user_stack_ptr = d[15:0];
        end
      end
      default: n = s;
    endcase
    return n;
  endfunction

  // ==========================================================
  // State
  regfile_pkg::regfile_state_t st_r;
  regfile_pkg::regfile_state_t st_nxt;
  logic resZero;
  logic resSign;

  always_comb begin
    resZero = 1'b0;
    resSign = 1'b0;
    case (aluFlags.size)
      regfile_pkg::SIZE_BYTE: begin
        resZero = (aluFlags.result[7:0] == 8'h0);
        resSign = aluFlags.result[7];
      end
      regfile_pkg::SIZE_WORD: begin
        resZero = (aluFlags.result[15:0] == 16'h0);
        resSign = aluFlags.result[15];
      end
      default: begin
        resZero = (aluFlags.result == 32'h0);
        resSign = aluFlags.result[31];
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0;
    st_nxt.pc = st_r.pc + {17'h0, dpReq.pcStep};
    if (busWr) begin
      st_nxt = writeSel(st_nxt, busAddr, busWdata);
    end
    if (busRd) begin
      st_nxt.rdata = readSel(st_r, busAddr);
    end
    // Datapath write lands after the bus so the executing instruction wins a collision
    if (dpReq.wrEn) begin
      st_nxt = writeSel(st_nxt, dpReq.wrSel, dpReq.wrData);
    end
    // ALU results override any explicit flag write in the same cycle
    if (aluFlags.aluValid) begin
      if (aluFlags.updC) begin
        st_nxt.flags[regfile_pkg::FLAG_C] = aluFlags.carry;
      end
      if (aluFlags.updZS) begin
        st_nxt.flags[regfile_pkg::FLAG_Z] = resZero;
        st_nxt.flags[regfile_pkg::FLAG_S] = resSign;
      end
      if (aluFlags.updO) begin
        st_nxt.flags[regfile_pkg::FLAG_O] = aluFlags.overflow;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= regfile_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  logic bankSel;
  assign bankSel = st_r.flags[regfile_pkg::FLAG_B];
  assign busRdata = st_r.rdata;
  assign dpRdData = readSel(st_r, dpReq.rdSel);
  assign view.regs = st_r.bank[bankSel];
  assign view.activeSp = st_r.flags[regfile_pkg::FLAG_U] ? st_r.interrupt_stack_ptr : st_r.user_stack_ptr;
  assign view.sb = st_r.sb;
  assign view.vtb = st_r.vtb;
  assign view.pc = st_r.pc;
  assign view.flags = st_r.flags;

  // ==========================================================
  // Checks
  logic [15:0] otherData0;
  assign otherData0 = st_r.bank[~bankSel].data[0];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_word_write;
    busWr && busAddr == regfile_pkg::SEL_DATA1 && !dpReq.wrEn |=> view.regs.data[1] == $past(busWdata[15:0]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("data 1 write lost");

  property p_byte_keep;
    busWr && busAddr == regfile_pkg::SEL_D0_UPPER && !dpReq.wrEn
      |=> view.regs.data[0] == {$past(busWdata[7:0]), $past(view.regs.data[0][7:0])};
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("upper byte write disturbed data 0");

  property p_pair_read;
    busRd && busAddr == regfile_pkg::SEL_DATA_PAIR_LOW
      |=> busRdata == {$past(view.regs.data[2]), $past(view.regs.data[0])};
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("data pair read wrong order");

  property p_addr_pair;
    busWr && busAddr == regfile_pkg::SEL_ADDR_PAIR && !dpReq.wrEn
      |=> view.regs.addr[1] == $past(busWdata[31:16]) && view.regs.addr[0] == $past(busWdata[15:0]);
  endproperty
  a_addr_pair: assert property (p_addr_pair) else $error("address pair halves wrong");

  property p_active_sp;
    busWr && busAddr == regfile_pkg::SEL_ACTIVE_SP && !dpReq.wrEn && st_r.flags[regfile_pkg::FLAG_U]
      |=> st_r.interrupt_stack_ptr == $past(busWdata[15:0]) && $stable(st_r.user_stack_ptr);
  endproperty
  a_active_sp: assert property (p_active_sp) else $error("active stack pointer write wrong");

  property p_zero;
    aluFlags.aluValid && aluFlags.updZS && aluFlags.size == regfile_pkg::SIZE_WORD
      && aluFlags.result[15:0] == 16'h0
      |=> view.flags[regfile_pkg::FLAG_Z] && !view.flags[regfile_pkg::FLAG_S];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not set");

  property p_sign;
    aluFlags.aluValid && aluFlags.updZS && aluFlags.size == regfile_pkg::SIZE_BYTE && aluFlags.result[7]
      |=> view.flags[regfile_pkg::FLAG_S] && !view.flags[regfile_pkg::FLAG_Z];
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag not set");

  property p_carry;
    aluFlags.aluValid && aluFlags.updC |=> view.flags[regfile_pkg::FLAG_C] == $past(aluFlags.carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag not captured");

  property p_overflow;
    aluFlags.aluValid && aluFlags.updO |=> view.flags[regfile_pkg::FLAG_O] == $past(aluFlags.overflow);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not captured");

  property p_bank_isolate;
    busWr && busAddr == regfile_pkg::SEL_DATA0 && !dpReq.wrEn |=> $stable(otherData0);
  endproperty
  a_bank_isolate: assert property (p_bank_isolate) else $error("write leaked into other bank");

  property p_pc_step;
    !(dpReq.wrEn && dpReq.wrSel == regfile_pkg::SEL_PC) && !(busWr && busAddr == regfile_pkg::SEL_PC)
      |=> view.pc == $past(view.pc) + {17'h0, $past(dpReq.pcStep)};
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");

  property p_flags_width;
    busRd && busAddr == regfile_pkg::SEL_FLAGS ##1 !busRd |-> busRdata[31:11] == 21'h0 ##1 busRdata == 32'h0;
  endproperty
  a_flags_width: assert property (p_flags_width) else $error("flag read wider than 11 bits");

  c_bank_switch: cover property ($rose(view.flags[regfile_pkg::FLAG_B]));
  c_pair_write: cover property (busWr && busAddr == regfile_pkg::SEL_DATA_PAIR_HIGH);
  c_alu_zero: cover property (aluFlags.aluValid && aluFlags.updZS && aluFlags.result == 32'h0);

endmodule

// ===== design/regfile_pkg.sv
package regfile_pkg;

  // ==========================================================
  // Register selects, shared by the bus and the datapath
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_DATA0 = 5'h00;
  localparam logic [4:0] SEL_DATA1 = 5'h01;
  localparam logic [4:0] SEL_DATA2 = 5'h02;
  localparam logic [4:0] SEL_DATA3 = 5'h03;
  localparam logic [4:0] SEL_ADDR_FIRST = 5'h04;
  localparam logic [4:0] SEL_ADDR_SECOND = 5'h05;
  localparam logic [4:0] SEL_FRAME_BASE = 5'h06;
  localparam logic [4:0] SEL_VTB = 5'h07;
  localparam logic [4:0] SEL_PC = 5'h08;
  localparam logic [4:0] SEL_USP = 5'h09;
  localparam logic [4:0] SEL_ISP = 5'h0a;
  localparam logic [4:0] SEL_STATIC_BASE = 5'h0b;
  localparam logic [4:0] SEL_FLAGS = 5'h0c;
  localparam logic [4:0] SEL_DATA_PAIR_LOW = 5'h0d;
  localparam logic [4:0] SEL_DATA_PAIR_HIGH = 5'h0e;
  localparam logic [4:0] SEL_ADDR_PAIR = 5'h0f;
  localparam logic [4:0] SEL_D0_UPPER = 5'h10;
  localparam logic [4:0] SEL_D0_LOWER = 5'h11;
  localparam logic [4:0] SEL_D1_UPPER = 5'h12;
  localparam logic [4:0] SEL_D1_LOWER = 5'h13;
  localparam logic [4:0] SEL_ACTIVE_SP = 5'h14;

  // ==========================================================
  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_D = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_O = 5;
  localparam int FLAG_U = 7;

  // ==========================================================
  // Operand sizes for flag evaluation
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0][15:0] data;
    logic [1:0][15:0] addr;
    logic [15:0] frameBase;
  } bank_t;

  typedef struct packed {
    bank_t [1:0] bank;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [15:0] user_stack_ptr;
    logic [15:0] interrupt_stack_ptr;
    logic [15:0] sb;
    logic [10:0] flags;
    logic [31:0] rdata;
  } regfile_state_t;

  typedef struct packed {
    logic wrEn;
    logic [4:0] wrSel;
    logic [31:0] wrData;
    logic [4:0] rdSel;
    logic [2:0] pcStep;
  } dp_req_t;

  typedef struct packed {
    logic aluValid;
    logic [1:0] size;
    logic [31:0] result;
    logic carry;
    logic overflow;
    logic updC;
    logic updZS;
    logic updO;
  } alu_flags_t;

  typedef struct packed {
    bank_t regs;
    logic [15:0] activeSp;
    logic [15:0] sb;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [10:0] flags;
  } cpu_view_t;

  // ==========================================================
  // Reset values
  localparam regfile_state_t STATE_RESET = '0;

endpackage

// ===== verif/alu_dp_model.sv
module alu_dp_model (
  input wire logic ref_clk,
  output regfile_pkg::dp_req_t dpReq,
  output regfile_pkg::alu_flags_t aluFlags
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Execution side of the core
  initial begin
    dpReq = '0;
    aluFlags = '0;
  end

  task automatic alu_op(input logic [1:0] size, input logic [31:0] res, input logic c, input logic o);
    aluFlags <= '{1'b1, size, res, c, o, 1'b1, 1'b1, 1'b1};
    @(posedge ref_clk);
  endtask

  // Stale result is scrambled so a flag update without valid shows up
  task automatic alu_idle();
    aluFlags <= '{1'b0, 2'h3, ~aluFlags.result, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  endtask

  task automatic dp_write(input logic [4:0] sel, input logic [31:0] d);
    dpReq.wrEn <= 1'b1;
    dpReq.wrSel <= sel;
    dpReq.rdSel <= sel;
    dpReq.wrData <= (sel == regfile_pkg::SEL_FLAGS) ? (d & ~(32'h1 << regfile_pkg::FLAG_D)) : d;
    @(posedge ref_clk);
  endtask

  task automatic dp_idle(input logic [2:0] step);
    dpReq.wrEn <= 1'b0;
    dpReq.wrData <= ~dpReq.wrData;
    dpReq.pcStep <= step;
  endtask
endmodule

// ===== verif/cpu_core_register_file_test.sv
module cpu_core_register_file_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, busWr, busRd, rdPend;
  logic [4:0] busAddr;
  logic [31:0] busWdata, busRdata, dpRdData, v, w;
  logic [31:0] shadow[12];
  logic [31:0] expQ[$];
  regfile_pkg::dp_req_t dpReq;
  regfile_pkg::alu_flags_t aluFlags;
  regfile_pkg::cpu_view_t view;
  int miscompares, samplesChecked, cycles;
  logic [1:0] aluSz[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
  logic [31:0] aluRes[5] = '{32'h0000_ff00, 32'h0001_8000, 32'h8000_0000, 32'h0000_0001, 32'hffff_0000};
  logic [1:0] aluCo[5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
  logic [10:0] aluExp[5] = '{11'h005, 11'h028, 11'h029, 11'h000, 11'h004};

  cpu_core_register_file i_dut (.ref_clk(clk), .nrst(nrst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .dpReq(dpReq), .aluFlags(aluFlags),
    .dpRdData(dpRdData), .view(view));
  alu_dp_model i_dp (.ref_clk(clk), .dpReq(dpReq), .aluFlags(aluFlags));

  // ==========================================
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] wmask(input logic [4:0] sel);
    if (sel == regfile_pkg::SEL_VTB || sel == regfile_pkg::SEL_PC) return 32'h000f_ffff;
    return 32'h0000_ffff;
  endfunction

  // Strobes are set afresh by every task so back-to-back cycles never drive twice
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    busRd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [4:0] a, input logic [31:0] e);
    busAddr <= a;
    busWdata <= ~busWdata;
    busWr <= 1'b0;
    busRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
  endtask

  task automatic bus_idle();
    busWr <= 1'b0;
    busRd <= 1'b0;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================
  // Clock, watchdog and read monitor
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_sim();
    end
  end

  // Read data live for one cycle only, zero at all other times
  always @(posedge clk) begin
    if (nrst && rdPend) check("busRdata", busRdata, expQ.pop_front());
    else if (nrst) check("busRdata idle", busRdata, 32'h0);
    rdPend = busRd & nrst;
  end

  // ==========================================
  // Scenarios
  initial begin
    nrst = 1'b0;
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = '0;
    busWdata = '0;
    rdPend = 1'b0;
    void'($urandom(43));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int s = 0; s < 32; s++) bus_rd(5'(s), 32'h0);
    for (int s = 0; s < 12; s++) begin
      v = $urandom();
      bus_wr(5'(s), v);
      shadow[s] = v & wmask(5'(s));
      bus_rd(5'(s), shadow[s]);
    end
    for (int s = 16; s < 20; s++) begin
      v = $urandom();
      bus_wr(5'(s), v);
      if (s[0]) shadow[s[1]][7:0] = v[7:0];
      else shadow[s[1]][15:8] = v[7:0];
      bus_rd(5'(s), {24'h0, v[7:0]});
    end
    bus_rd(regfile_pkg::SEL_DATA0, shadow[0]);
    bus_rd(regfile_pkg::SEL_DATA1, shadow[1]);
    v = $urandom();
    bus_wr(regfile_pkg::SEL_DATA_PAIR_LOW, v);
    bus_rd(regfile_pkg::SEL_DATA2, {16'h0, v[31:16]});
    w = $urandom();
    bus_wr(regfile_pkg::SEL_DATA_PAIR_HIGH, w);
    bus_rd(regfile_pkg::SEL_DATA3, {16'h0, w[31:16]});
    w = w ^ v;
    bus_wr(regfile_pkg::SEL_ADDR_PAIR, w);
    bus_rd(regfile_pkg::SEL_ADDR_SECOND, {16'h0, w[31:16]});
    bus_rd(regfile_pkg::SEL_ADDR_FIRST, {16'h0, w[15:0]});
    // Bank 1 starts from reset while bank 0 keeps its contents; debug bit left at 0
    bus_wr(regfile_pkg::SEL_FLAGS, 32'h0000_0010);
    bus_rd(regfile_pkg::SEL_DATA0, 32'h0);
    bus_wr(regfile_pkg::SEL_DATA0, 32'h0000_a5c3);
    bus_idle();
    #1;
    check("view data0", {16'h0, view.regs.data[0]}, 32'h0000_a5c3);
    @(posedge clk);
    bus_wr(regfile_pkg::SEL_FLAGS, 32'h0);
    bus_rd(regfile_pkg::SEL_DATA0, {16'h0, v[15:0]});
    bus_rd(regfile_pkg::SEL_ACTIVE_SP, shadow[9]);
    bus_wr(regfile_pkg::SEL_FLAGS, 32'h0000_0080);
    bus_rd(regfile_pkg::SEL_ACTIVE_SP, shadow[10]);
    bus_idle();
    #1;
    check("view activeSp", {16'h0, view.activeSp}, shadow[10]);
    @(posedge clk);
    bus_wr(regfile_pkg::SEL_FLAGS, 32'h0);
    bus_idle();
    for (int i = 0; i < 5; i++) begin
      i_dp.alu_op(aluSz[i], aluRes[i], aluCo[i][1], aluCo[i][0]);
      i_dp.alu_idle();
      #1;
      check("view flags", {21'h0, view.flags}, {21'h0, aluExp[i]});
      @(posedge clk);
    end
    // Datapath write wins over a bus write in the same cycle
    fork
      i_dp.dp_write(regfile_pkg::SEL_STATIC_BASE, 32'h0000_1234);
      bus_wr(regfile_pkg::SEL_STATIC_BASE, 32'h0000_5678);
    join
    bus_idle();
    i_dp.dp_idle(3'h0);
    #1;
    check("view sb", {16'h0, view.sb}, 32'h0000_1234);
    check("dpRdData", dpRdData, 32'h0000_1234);
    @(posedge clk);
    // Counter wraps at 20 bits
    bus_wr(regfile_pkg::SEL_PC, 32'h000f_fffd);
    bus_idle();
    i_dp.dp_idle(3'h2);
    repeat (3) @(posedge clk);
    i_dp.dp_idle(3'h0);
    #1;
    check("view pc", {12'h0, view.pc}, 32'h0000_0003);
    @(posedge clk);
    bus_wr(5'h15, 32'hffff_ffff);
    bus_rd(5'h15, 32'h0);
    bus_rd(regfile_pkg::SEL_STATIC_BASE, 32'h0000_1234);
    // Flags left by the last ALU step: zero flag only; an idle cycle follows for the width check
    bus_rd(regfile_pkg::SEL_FLAGS, 32'h0000_0004);
    bus_idle();
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
